/* hw/axis_override_consts.svh */
// Offsets, field positions, reset values and limits for the override and jog command handler
`ifndef AXIS_OVERRIDE_CONSTS_SVH
`define AXIS_OVERRIDE_CONSTS_SVH

`define AXIS_COUNT 2
`define AXIS_SEL_W 16
`define OPERAND_W 32
`define SPEED_MAX_PPS 32'h000186a0
`define ERR_CODE_W 16
`define ERR_NONE 16'h0000
`define ERR_SPEED_PHASE 16'h0179
`define ERR_JOG_MOVING 16'h0191
`define ERR_JOG_INHIBIT 16'h0192

`define REG_ADDR_W 8
`define REG_DATA_W 32
`define REG_STATUS 8'h00
`define REG_MASK 8'h04
`define REG_ERR_CODE 8'h08
`define REG_AXIS0 8'h0c
`define REG_AXIS1 8'h10

`define ST_W 6
`define ST_OPERAND 0
`define ST_SPEED_REJ 1
`define ST_JOG_REJ 2
`define ST_SPEED_SET 3
`define ST_POS_FIRE 4
`define ST_JOG_START 5
`define STATUS_RST 6'h00
`define MASK_RST 6'h00

`endif

/* hw/axis_override_pkg.sv */
// Types shared by the override and jog command handler
package axis_override_pkg;

  // Motion phase reported by the profile engine of one axis
  typedef enum logic [2:0] {
    PHASE_IDLE = 3'b000,
    PHASE_ACCEL = 3'b001,
    PHASE_CRUISE = 3'b010,
    PHASE_DECEL = 3'b011,
    PHASE_DWELL = 3'b100
  } phase_type;

  // Position-armed override state of one axis
  typedef enum logic {
    ARM_IDLE = 1'b0,
    ARM_WAIT = 1'b1
  } arm_state_type;

  // What the axis tells the handler
  typedef struct packed {
    phase_type phase;
    logic inhibit;
    logic [31:0] position;
    logic [31:0] jog_speed;
  } axis_status_type;

  // What the handler tells the axis
  typedef struct packed {
    logic speed_load;
    logic [31:0] speed;
    logic jog_start;
    logic [31:0] jog_target;
    logic [31:0] jog_speed;
  } axis_drive_type;

endpackage

/* hw/axis_speed_override_inching.sv */
// Speed override, position-armed speed override and jog command handler for two axes
//
// Summary of operation
// - Axis selector 0 is the first axis and 1 the second; any other value sets the operand error flag and does nothing.
// - A command acts only on a rising edge of its condition, so each new request needs a fresh rise.
// - An accepted immediate speed change replaces the running speed of the selected axis, range 0 to 100,000 pps.
// - Immediate speed change is taken only in acceleration or cruise, else code 377 is reported and the step runs on.
// - A speed change touches only the running step, never the stored step speed.
// - A position-armed change latches a signed trigger and a speed and switches the speed when the position reaches it.
// - A position-armed change issued in deceleration or dwell is dropped silently with no error code.
// - An accepted jog moves the axis to a signed target at the jog speed of its origin/manual parameter set.
// - A jog is refused with code 401 if the axis is moving and 402 if output is inhibited, starting no motion.
//
// Chosen here: the plain strobed port and the register offsets.
`include "axis_override_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module axis_speed_override_inching
  import axis_override_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic speed_change_cmd_i,
  input wire logic speed_change_at_position_cmd_i,
  input wire logic jog_to_position_cmd_i,
  input wire logic [`AXIS_SEL_W-1:0] axis_select_i,
  input wire logic [`OPERAND_W-1:0] first_operand_i,
  input wire logic [`OPERAND_W-1:0] second_operand_i,
  input wire axis_status_type [`AXIS_COUNT-1:0] axis_status_i,
  input wire logic [`REG_ADDR_W-1:0] reg_addr_i,
  input wire logic [`REG_DATA_W-1:0] reg_wr_data_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [`REG_DATA_W-1:0] reg_rd_data_o,
  output logic irq_o,
  output logic operand_error_flag_o,
  output logic [`ERR_CODE_W-1:0] error_code_o,
  output axis_drive_type [`AXIS_COUNT-1:0] axis_drive_o
);

  // Speeds above the documented maximum are held at the maximum
  function automatic logic [31:0] clamp_speed(input logic [31:0] req);
    clamp_speed = (req > `SPEED_MAX_PPS) ? `SPEED_MAX_PPS : req;
  endfunction

  // Command conditions sampled one scan back
  logic [2:0] cmd_prev_r;
  logic [2:0] cmd_now;
  logic [2:0] cmd_rise;

  assign cmd_now = {jog_to_position_cmd_i, speed_change_at_position_cmd_i, speed_change_cmd_i};
  assign cmd_rise = cmd_now & ~cmd_prev_r;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      cmd_prev_r <= 3'h0;
    else
      cmd_prev_r <= cmd_now;
  end

  // Axis selector decode; upper bits must all be zero
  logic axis_valid;
  logic axis_pick;
  logic any_rise;
  logic operand_err_ev;

  assign axis_valid = (axis_select_i[`AXIS_SEL_W-1:1] == 15'h0000);
  assign axis_pick = axis_select_i[0];
  assign any_rise = |cmd_rise;
  assign operand_err_ev = any_rise & ~axis_valid;

  // Per-axis event vectors gathered from the generate loop
  logic [`AXIS_COUNT-1:0] ev_speed_rej;
  logic [`AXIS_COUNT-1:0] ev_speed_set;
  logic [`AXIS_COUNT-1:0] ev_pos_fire;
  logic [`AXIS_COUNT-1:0] ev_jog_moving;
  logic [`AXIS_COUNT-1:0] ev_jog_inhibit;
  logic [`AXIS_COUNT-1:0] ev_jog_start;
  logic [`AXIS_COUNT-1:0] armed_view;
  logic [`OPERAND_W-1:0] trig_view [`AXIS_COUNT];

  genvar ax;
  generate
    for (ax = 0; ax < `AXIS_COUNT; ax = ax + 1)
    begin : g_axis
      arm_state_type arm_r;
      arm_state_type arm_nxt;
      logic signed [31:0] trig_pos_r;
      logic [31:0] trig_speed_r;
      logic signed [31:0] prev_pos_r;
      axis_drive_type drive_r;
      axis_drive_type drive_nxt;

      wire logic hit;
      wire logic moving;
      wire logic run_ok;
      wire logic signed [31:0] pos;
      wire logic reached;
      wire logic sc_take;
      wire logic ps_take;
      wire logic jg_take;
      wire logic fire;

      // Command steering to this axis
      assign hit = axis_valid & (axis_pick == 1'(ax));
      assign moving = (axis_status_i[ax].phase != PHASE_IDLE);
      assign run_ok = (axis_status_i[ax].phase == PHASE_ACCEL) | (axis_status_i[ax].phase == PHASE_CRUISE);
      assign pos = axis_status_i[ax].position;

      // Immediate speed change: take in accel/cruise, else report 377
      assign sc_take = cmd_rise[0] & hit & run_ok;
      assign ev_speed_rej[ax] = cmd_rise[0] & hit & ~run_ok;

      // Position-armed change: decel, dwell or idle drops it silently
      assign ps_take = cmd_rise[1] & hit & run_ok;

      // Jog: refuse when moving (401) or inhibited (402)
      assign ev_jog_moving[ax] = cmd_rise[2] & hit & moving;
      assign ev_jog_inhibit[ax] = cmd_rise[2] & hit & ~moving & axis_status_i[ax].inhibit;
      assign jg_take = cmd_rise[2] & hit & ~moving & ~axis_status_i[ax].inhibit;

      // Trigger counts as reached on equality or on crossing it in either direction,
      // since a fast axis may step over the exact value between two scans
      assign reached = (pos == trig_pos_r) |
                       ((prev_pos_r < trig_pos_r) & (pos > trig_pos_r)) |
                       ((prev_pos_r > trig_pos_r) & (pos < trig_pos_r));
      // Immediate change in the same scan wins over the armed one
      assign fire = (arm_r == ARM_WAIT) & moving & reached & ~sc_take;

      assign ev_speed_set[ax] = sc_take;
      assign ev_pos_fire[ax] = fire;
      assign ev_jog_start[ax] = jg_take;
      assign armed_view[ax] = (arm_r == ARM_WAIT);
      assign trig_view[ax] = trig_pos_r;

      // Arm state: a new arm replaces an older one; stopping disarms
      always_comb
      begin
        arm_nxt = arm_r;
        unique case (arm_r)
          ARM_IDLE:
          begin
            if (ps_take)
              arm_nxt = ARM_WAIT;
          end
          ARM_WAIT:
          begin
            if (ps_take)
              arm_nxt = ARM_WAIT;
            else if (fire | ~moving)
              arm_nxt = ARM_IDLE;
          end
        endcase
      end

      // Drive toward the axis; only the live speed is loaded, the step table is never written
      always_comb
      begin
        drive_nxt = drive_r;
        drive_nxt.speed_load = sc_take | fire;
        drive_nxt.jog_start = jg_take;
        if (sc_take)
          drive_nxt.speed = clamp_speed(first_operand_i);
        else if (fire)
          drive_nxt.speed = trig_speed_r;
        if (jg_take)
        begin
          drive_nxt.jog_target = first_operand_i;
          drive_nxt.jog_speed = axis_status_i[ax].jog_speed;
        end
      end

      always_ff @(posedge clk_sys_i)
      begin
        if (rst_i)
        begin
          arm_r <= ARM_IDLE;
          trig_pos_r <= 32'sh00000000;
          trig_speed_r <= 32'h00000000;
          prev_pos_r <= 32'sh00000000;
          drive_r <= '0;
        end
        else
        begin
          arm_r <= arm_nxt;
          prev_pos_r <= pos;
          drive_r <= drive_nxt;
          if (ps_take)
          begin
            trig_pos_r <= first_operand_i;
            trig_speed_r <= clamp_speed(second_operand_i);
          end
        end
      end

      assign axis_drive_o[ax] = drive_r;
    end
  endgenerate

  // Event summary for status and error code
  logic [`ST_W-1:0] events;
  logic [`ERR_CODE_W-1:0] err_code_nxt;
  logic err_event;

  assign events[`ST_OPERAND] = operand_err_ev;
  assign events[`ST_SPEED_REJ] = |ev_speed_rej;
  assign events[`ST_JOG_REJ] = |(ev_jog_moving | ev_jog_inhibit);
  assign events[`ST_SPEED_SET] = |ev_speed_set;
  assign events[`ST_POS_FIRE] = |ev_pos_fire;
  assign events[`ST_JOG_START] = |ev_jog_start;

  // Jog codes win if both commands fail in one scan; they are the later command
  assign err_event = events[`ST_SPEED_REJ] | events[`ST_JOG_REJ];
  assign err_code_nxt = (|ev_jog_inhibit) ? `ERR_JOG_INHIBIT :
                        (|ev_jog_moving) ? `ERR_JOG_MOVING :
                        `ERR_SPEED_PHASE;

  // Register bus decode
  logic wr_status;
  logic wr_mask;
  logic wr_err;

  assign wr_status = reg_wr_i & (reg_addr_i == `REG_STATUS);
  assign wr_mask = reg_wr_i & (reg_addr_i == `REG_MASK);
  assign wr_err = reg_wr_i & (reg_addr_i == `REG_ERR_CODE);

  // Sticky status: a set in the same cycle as a write-one-clear wins
  logic [`ST_W-1:0] status_r;
  logic [`ST_W-1:0] status_nxt;
  logic [`ST_W-1:0] mask_r;
  logic [`ST_W-1:0] mask_nxt;
  logic [`ERR_CODE_W-1:0] err_code_r;
  logic [`ERR_CODE_W-1:0] err_code_reg_nxt;
  logic irq_r;

  assign status_nxt = (status_r & ~(wr_status ? reg_wr_data_i[`ST_W-1:0] : 6'h00)) | events;
  assign mask_nxt = wr_mask ? reg_wr_data_i[`ST_W-1:0] : mask_r;
  // Code holds until replaced by a newer failure or cleared by a write to the error code register
  assign err_code_reg_nxt = err_event ? err_code_nxt : (wr_err ? `ERR_NONE : err_code_r);

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      status_r <= `STATUS_RST;
      mask_r <= `MASK_RST;
      err_code_r <= `ERR_NONE;
      irq_r <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      err_code_r <= err_code_reg_nxt;
      irq_r <= |(status_nxt & mask_nxt);
    end
  end

  // Read mux; unmapped addresses read zero
  logic [`REG_DATA_W-1:0] rd_mux;
  logic [`REG_DATA_W-1:0] rd_data_r;

  assign rd_mux = (reg_addr_i == `REG_STATUS) ? {26'h0000000, status_r} :
                  (reg_addr_i == `REG_MASK) ? {26'h0000000, mask_r} :
                  (reg_addr_i == `REG_ERR_CODE) ? {16'h0000, err_code_r} :
                  (reg_addr_i == `REG_AXIS0) ? {armed_view[0], trig_view[0][30:0]} :
                  (reg_addr_i == `REG_AXIS1) ? {armed_view[1], trig_view[1][30:0]} :
                  32'h00000000;

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      rd_data_r <= 32'h00000000;
    else
      rd_data_r <= reg_rd_i ? rd_mux : 32'h00000000;
  end

  assign reg_rd_data_o = rd_data_r;
  assign irq_o = irq_r;
  assign operand_error_flag_o = status_r[`ST_OPERAND];
  assign error_code_o = err_code_r;

endmodule

`default_nettype wire

/* verification/seq_model.sv */
// Controller model that raises the speed change condition
`timescale 1ns/1ns
`default_nettype none
module seq_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic dwell_i,
  output logic cmd_o
);
  // Request registered one scan late and high for as long as it is held; dwell gates it off
  always_ff @(posedge clk_sys_i)
    cmd_o <= !rst_i && req_i && !dwell_i;
endmodule
`default_nettype wire

/* verification/axis_override_assertions.sv */
// Port assertions for the override and jog command handler
`include "axis_override_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module axis_override_assertions
  import axis_override_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic speed_change_cmd_i,
  input wire logic speed_change_at_position_cmd_i,
  input wire logic jog_to_position_cmd_i,
  input wire logic [`AXIS_SEL_W-1:0] axis_select_i,
  input wire logic [`OPERAND_W-1:0] first_operand_i,
  input wire axis_status_type [`AXIS_COUNT-1:0] axis_status_i,
  input wire logic reg_wr_i,
  input wire logic operand_error_flag_o,
  input wire logic [`ERR_CODE_W-1:0] error_code_o,
  input wire axis_drive_type [`AXIS_COUNT-1:0] axis_drive_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic [2:0] prev_r;
  // Cleared in reset, since a condition high at release counts as a rise
  always_ff @(posedge clk_sys_i)
    prev_r <= rst_i ? 3'h0 : {jog_to_position_cmd_i, speed_change_at_position_cmd_i, speed_change_cmd_i};
  // Rise detection and axis 0 phase decode
  wire sr = speed_change_cmd_i & ~prev_r[0];
  wire pr = speed_change_at_position_cmd_i & ~prev_r[1];
  wire jr = jog_to_position_cmd_i & ~prev_r[2];
  wire a0 = axis_select_i == 16'h0000;
  wire [2:0] ph = axis_status_i[0].phase;
  wire run = ph == PHASE_ACCEL || ph == PHASE_CRUISE;
  wire idle = ph == PHASE_IDLE;
  wire [31:0] sp = first_operand_i > `SPEED_MAX_PPS ? `SPEED_MAX_PPS : first_operand_i;
  wire no_jog = !axis_drive_o[0].jog_start && !axis_drive_o[1].jog_start;

  AST_SEL: assert property ((sr || pr || jr) && axis_select_i > 16'h0001 |=>
    operand_error_flag_o && no_jog) else $error("bad selector accepted");
  AST_SPD: assert property (sr && a0 && run |=>
    axis_drive_o[0].speed_load && axis_drive_o[0].speed == $past(sp)) else $error("speed not applied");
  AST_SPD_REJ: assert property (sr && a0 && !run && !jr |=>
    error_code_o == `ERR_SPEED_PHASE) else $error("speed refusal code wrong");
  AST_HELD: assert property (jog_to_position_cmd_i && prev_r[2] |=>
    no_jog) else $error("held condition acted on");
  AST_JOG: assert property (jr && a0 && idle && !axis_status_i[0].inhibit |=>
    axis_drive_o[0].jog_start && axis_drive_o[0].jog_target == $past(first_operand_i)
    && axis_drive_o[0].jog_speed == $past(axis_status_i[0].jog_speed)) else $error("jog not started");
  AST_MOVE: assert property (jr && a0 && !idle |=>
    error_code_o == `ERR_JOG_MOVING && no_jog) else $error("jog while moving");
  AST_ARM: assert property (pr && a0 && !run && !idle && !sr && !jr && !reg_wr_i |=>
    $stable(error_code_o)) else $error("dropped change gave a code");
  AST_FLAG: assert property (operand_error_flag_o && !reg_wr_i |=>
    operand_error_flag_o) else $error("error flag dropped");
endmodule
`default_nettype wire

/* verification/axis_speed_override_inching_test.sv */
// Self-checking bench for the override and jog command handler
`include "axis_override_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module axis_speed_override_inching_test
  import axis_override_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0;
  logic [2:0] v = 3'h0;
  logic [15:0] sel = 16'h0000;
  logic [31:0] op1 = 32'h0;
  logic [31:0] op2 = 32'h0;
  axis_status_type [1:0] st = '0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic spd;
  logic [31:0] rdata;
  logic irq;
  logic flag;
  logic [15:0] code;
  axis_drive_type [1:0] drv;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;

  always #25 clk_sys_i = ~clk_sys_i;

  seq_model seq_model_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req),
    .dwell_i(st[sel[0]].phase == PHASE_DWELL), .cmd_o(spd));
  axis_speed_override_inching axis_speed_override_inching_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .speed_change_cmd_i(spd), .speed_change_at_position_cmd_i(v[1]), .jog_to_position_cmd_i(v[2]),
    .axis_select_i(sel), .first_operand_i(op1), .second_operand_i(op2), .axis_status_i(st),
    .reg_addr_i(addr), .reg_wr_data_i(wd), .reg_wr_i(we), .reg_rd_i(re), .reg_rd_data_o(rdata),
    .irq_o(irq), .operand_error_flag_o(flag), .error_code_o(code), .axis_drive_o(drv));

  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // Clamp to the pulse-rate limit
  function automatic logic [31:0] exp_spd(input logic [31:0] o);
    return (o > `SPEED_MAX_PPS) ? `SPEED_MAX_PPS : o;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk_sys_i);
    we <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    addr <= a;
    re <= 1'b1;
    @(posedge clk_sys_i);
    re <= 1'b0;
    #1;
    chk("rdata", e, rdata);
  endtask

  // Raise command conditions m with operands; speed change goes through the model, one scan later
  task automatic go(input logic [2:0] m, input logic [15:0] a, input phase_type p, input logic inh,
    input logic [31:0] o1, input logic [31:0] o2, input int h);
    @(posedge clk_sys_i);
    sel <= a;
    op1 <= o1;
    op2 <= o2;
    st[a[0]].phase <= p;
    st[a[0]].inhibit <= inh;
    req <= m[0];
    v <= m;
    repeat (h + 1) @(posedge clk_sys_i);
    req <= 1'b0;
    v <= 3'h0;
    if (m[0])
      @(posedge clk_sys_i);
    #1;
  endtask

  // Cycle ceiling against a hang
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      failures = failures + 1;
      finish_test();
    end
  end

  initial
  begin
    logic [15:0] a;
    phase_type p;
    logic [31:0] o;
    logic [15:0] ec;
    void'($urandom(57870));
    st[0].jog_speed = $urandom();
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    // Random speed changes in every phase but dwell, some above the limit
    repeat (12)
    begin
      a = 16'($urandom_range(1, 0));
      p = phase_type'($urandom_range(3, 0));
      o = $urandom_range(32'h30000, 0);
      go(3'b001, a, p, 1'b0, o, 0, 0);
      chk("load", 32'(p == PHASE_ACCEL || p == PHASE_CRUISE), 32'(drv[a[0]].speed_load));
      if (p == PHASE_ACCEL || p == PHASE_CRUISE)
        chk("speed", exp_spd(o), drv[a[0]].speed);
      else
        chk("code", 32'(`ERR_SPEED_PHASE), 32'(code));
    end
    // Dwell gating in the controller keeps the request off; a cleared code stays clear
    wr(`REG_ERR_CODE, 32'h0);
    go(3'b001, 16'h0001, PHASE_DWELL, 1'b0, 32'd10, 0, 0);
    chk("load", 0, 32'(drv[1].speed_load));
    chk("code", 0, 32'(code));
    wr(`REG_STATUS, 32'h3f);
    wr(`REG_MASK, 32'h08);
    // Jog accepted, refused while moving, refused while inhibited
    for (int i = 0; i < 3; i++)
    begin
      o = $urandom();
      go(3'b100, 16'h0000, phase_type'(i == 1 ? PHASE_CRUISE : PHASE_IDLE), i == 2, o, 0, 0);
      chk("start", 32'(i == 0), 32'(drv[0].jog_start));
      if (i == 0)
        chk("target", o, drv[0].jog_target);
      else
        chk("code", i == 1 ? 32'(`ERR_JOG_MOVING) : 32'(`ERR_JOG_INHIBIT), 32'(code));
    end
    chk("jspeed", st[0].jog_speed, drv[0].jog_speed);
    chk("irq", 0, 32'(irq));
    rd(`REG_STATUS, 32'h24);
    go(3'b001, 16'h0000, PHASE_ACCEL, 1'b0, 32'd5000, 0, 0);
    chk("irq", 1, 32'(irq));
    wr(`REG_STATUS, 32'h08);
    chk("irq", 0, 32'(irq));
    rd(8'hfc, 0);
    // Held jog condition must start only once
    go(3'b100, 16'h0000, PHASE_IDLE, 1'b0, 32'd5, 0, 3);
    chk("start", 0, 32'(drv[0].jog_start));
    // Out of range selector raises the flag, which holds until cleared
    wr(`REG_STATUS, 32'h3f);
    go(3'b001, 16'h0002 + 16'($urandom_range(200, 0)), PHASE_CRUISE, 1'b0, 32'd7, 0, 0);
    chk("flag", 1, 32'(flag));
    rd(`REG_STATUS, 32'h01);
    wr(`REG_STATUS, 32'h01);
    chk("flag", 0, 32'(flag));
    // Armed change in deceleration is dropped; position already equals trigger
    ec = code;
    go(3'b010, 16'h0000, PHASE_DECEL, 1'b0, 0, 32'd1000, 0);
    @(posedge clk_sys_i);
    #1;
    chk("code", 32'(ec), 32'(code));
    chk("fire", 0, 32'(drv[0].speed_load));
    go(3'b010, 16'h0000, PHASE_CRUISE, 1'b0, 32'd200, 32'd15000, 0);
    @(posedge clk_sys_i);
    st[0].position <= 32'd250;
    @(posedge clk_sys_i);
    #1;
    chk("fire", 1, 32'(drv[0].speed_load));
    chk("speed", 32'd15000, drv[0].speed);
    // Fired change disarms; latched trigger stays readable
    rd(`REG_AXIS0, 32'h000000c8);
    finish_test();
  end
endmodule

bind axis_speed_override_inching axis_override_assertions axis_override_assertions_i (.clk_sys_i(clk_sys_i),
  .rst_i(rst_i), .speed_change_cmd_i(speed_change_cmd_i),
  .speed_change_at_position_cmd_i(speed_change_at_position_cmd_i), .jog_to_position_cmd_i(jog_to_position_cmd_i),
  .axis_select_i(axis_select_i), .first_operand_i(first_operand_i), .axis_status_i(axis_status_i),
  .reg_wr_i(reg_wr_i), .operand_error_flag_o(operand_error_flag_o), .error_code_o(error_code_o),
  .axis_drive_o(axis_drive_o));
`default_nettype wire
